// >>> src/pcm_clock_mult.sv
// two clock multiplier circuits with lock indicators, APB registers, irq
// assumes reference clocks arrive on pins asynchronous to CLOCK_IN
`timescale 1ns/1ps
`default_nettype none
module pcm_clock_mult
   import pcm_pkg::*;
(
   input  wire logic              CLOCK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [7:0]        PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   output logic      [31:0]       PRDATA_OUT,
   output logic                   PREADY_OUT,
   output logic                   PSLVERR_OUT,
   input  wire logic [NCIRC-1:0]  REF_CLK_IN,
   output logic      [NCIRC-1:0]  GEN_CLK_OUT,
   input  wire logic [NCIRC-1:0]  LOCK_PIN_IN,
   output logic      [NCIRC-1:0]  LOCK_PIN_OUT,
   output logic      [NCIRC-1:0]  LOCK_PIN_OE_OUT,
   output logic                   IRQ_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // state
   pcm_cfg_t           cfg      [NCIRC];
   pcm_cfg_t           next_cfg [NCIRC];
   pcm_state_t         st       [NCIRC];
   pcm_state_t         next_st  [NCIRC];
   logic [15:0]        cnt      [NCIRC];
   logic [15:0]        next_cnt [NCIRC];
   logic [15:0]        per      [NCIRC];
   logic [15:0]        next_per [NCIRC];
   logic [15:0]        acq      [NCIRC];
   logic [15:0]        next_acq [NCIRC];
   logic [31:0]        acc      [NCIRC];
   logic [31:0]        next_acc [NCIRC];
   logic [15:0]        hold     [NCIRC];
   logic [15:0]        next_hold[NCIRC];
   logic [NCIRC-1:0]   ref_s1, ref_s2, ref_s3, lin_s1, lin_s2;
   logic [NCIRC-1:0]   gen, next_gen, lock, next_lock;
   logic [NCIRC-1:0]   gp_out, gp_oe, next_gp_out, next_gp_oe;
   logic [NCIRC-1:0]   pin, next_pin, pin_oe, next_pin_oe;
   logic [5:0]         irq_st, next_irq_st, irq_en, next_irq_en, ev;
   logic [31:0]        rdata, next_rdata;
   logic               pready, next_pready, pslverr, next_pslverr, irq;
   logic               next_irq;
   logic [NCIRC-1:0]   valid, cfg_wr, rise;
   logic [28:0]        thr      [NCIRC];
   logic               wr, rd;
   logic [15:0]        dper;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the second stage feeds logic, the third reference stage (ref_s3) only the edge detect
   always_ff @(posedge CLOCK_IN) begin
      ref_s1 <= REF_CLK_IN;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      lin_s1 <= LOCK_PIN_IN;
      lin_s2 <= lin_s1;
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode and register writes; access takes two cycles
   assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN && !pready;
   assign rd = PSEL_IN && PENABLE_IN && !PWRITE_IN && !pready;
   assign cfg_wr[0] = wr && (PADDR_IN == ADDR_CFG0 || PADDR_IN == ADDR_DLY0);
   assign cfg_wr[1] = wr && (PADDR_IN == ADDR_CFG1 || PADDR_IN == ADDR_DLY1);

   always_comb begin
      next_pready  = PSEL_IN && PENABLE_IN && !pready;
      next_pslverr = 1'b0;
      next_rdata   = 32'h0000_0000;
      next_gp_out  = gp_out;
      next_gp_oe   = gp_oe;
      next_irq_en  = irq_en;
      for (int i = 0; i < NCIRC; i++) begin
         next_cfg[i] = cfg[i];
      end
      if (PADDR_IN == ADDR_CFG0 || PADDR_IN == ADDR_CFG1) begin
         next_rdata = {8'h00, cfg[PADDR_IN[3]].phase, cfg[PADDR_IN[3]].lock_en,
                       cfg[PADDR_IN[3]].n, cfg[PADDR_IN[3]].k,
                       cfg[PADDR_IN[3]].m};
         if (wr) begin
            next_cfg[PADDR_IN[3]].m       = PWDATA_IN[M_LSB +: 8];
            next_cfg[PADDR_IN[3]].k       = PWDATA_IN[K_LSB +: 8];
            next_cfg[PADDR_IN[3]].n       = PWDATA_IN[N_LSB +: 5];
            // phase is a count of quarter periods
            next_cfg[PADDR_IN[3]].phase   = PWDATA_IN[PH_LSB +: 2];
            next_cfg[PADDR_IN[3]].lock_en = PWDATA_IN[LEN_BIT];
         end
      end else if (PADDR_IN == ADDR_DLY0 || PADDR_IN == ADDR_DLY1) begin
         next_rdata = {16'h0000, cfg[PADDR_IN[3]].delay};
         if (wr) begin
            next_cfg[PADDR_IN[3]].delay = PWDATA_IN[15:0];
         end
      end else if (PADDR_IN == ADDR_STATUS) begin
         next_rdata = {26'h000_0000, valid, lock, 2'b00};
         next_rdata[1:0] = 2'(per[0] == 16'h0000 ? 2'b00 : 2'b01) |
                           2'(per[1] == 16'h0000 ? 2'b00 : 2'b10);
      end else if (PADDR_IN == ADDR_IRQ_ST) begin
         next_rdata = {26'h000_0000, irq_st};
      end else if (PADDR_IN == ADDR_IRQ_CLR) begin
         next_rdata = 32'h0000_0000;
      end else if (PADDR_IN == ADDR_IRQ_EN) begin
         next_rdata = {26'h000_0000, irq_en};
         if (wr) begin
            next_irq_en = PWDATA_IN[5:0];
         end
      end else if (PADDR_IN == ADDR_GPIO) begin
         next_rdata = {26'h000_0000, lin_s2, gp_oe, gp_out};
         if (wr) begin
            next_gp_out = PWDATA_IN[1:0];
            next_gp_oe  = PWDATA_IN[3:2];
         end
      end else begin
         // unmapped: error, reads zero
         next_pslverr = wr || rd;
      end
      if (!rd) begin
         next_rdata = rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-circuit reference measurement, lock machine and clock generator
   // both loops multiply their own link clock input
   always_comb begin
      dper = 16'h0000;
      for (int i = 0; i < NCIRC; i++) begin
         rise[i]      = ref_s2[i] && !ref_s3[i];
         thr[i]       = pcm_thresh(cfg[i], per[i]);
         valid[i]     = pcm_valid(cfg[i], per[i], i[0]);
         next_st[i]   = st[i];
         next_acq[i]  = acq[i];
         next_acc[i]  = acc[i];
         next_hold[i] = hold[i];
         next_gen[i]  = 1'b0;
         next_per[i]  = per[i];
         next_cnt[i]  = (cnt[i] == PER_MAX) ? cnt[i] : cnt[i] + 16'h0001;
         if (rise[i]) begin
            next_cnt[i] = 16'h0001;
            next_per[i] = cnt[i];
         end
         dper = (cnt[i] > per[i]) ? cnt[i] - per[i] : per[i] - cnt[i];
         case (st[i])
            ST_IDLE: begin
               next_acq[i] = 16'h0000;
               if (rise[i]) begin
                  next_st[i] = ST_ACQ;
               end
            end
            ST_ACQ: begin
               next_acq[i] = acq[i] + 16'h0001;
               if (rise[i] && dper <= 16'h0001 && valid[i]) begin
                  next_st[i]   = ST_HOLD;
                  next_hold[i] = cfg[i].delay;
                  // start point of accumulator sets the quarter period step of the phase (phase bit 0)
                  next_acc[i]  = cfg[i].phase[0] ? 32'(thr[i] >> 1)
                                                 : 32'h0000_0000;
               end else if (acq[i] == 16'(LOCK_CYC - 1)) begin
                  next_acq[i] = 16'h0000;
               end
            end
            ST_HOLD: begin
               // output start held off by the delay count
               next_gen[i]  = 1'b0;
               next_hold[i] = hold[i] - 16'h0001;
               if (hold[i] == 16'h0000) begin
                  next_st[i]  = ST_RUN;
                  next_gen[i] = cfg[i].phase[1];
               end
            end
            ST_RUN: begin
               next_gen[i] = gen[i];
               next_acc[i] = acc[i] + 32'({cfg[i].m, 1'b0});
               if (next_acc[i] >= 32'(thr[i])) begin
                  next_acc[i] = next_acc[i] - 32'(thr[i]);
                  next_gen[i] = !gen[i];
               end
            end
            default: next_st[i] = ST_IDLE;
         endcase
         // lost reference or new setting forces reacquisition
         if (cnt[i] == PER_MAX || cfg_wr[i]) begin
            next_st[i]  = (cnt[i] == PER_MAX) ? ST_IDLE : ST_ACQ;
            next_acq[i] = 16'h0000;
            next_gen[i] = 1'b0;
            next_per[i] = (cnt[i] == PER_MAX) ? 16'h0000 : per[i];
         end
         // lock follows the machine leaving acquisition
         next_lock[i] = (next_st[i] == ST_HOLD) || (next_st[i] == ST_RUN);
         // pin shows lock when enabled, else plain gpio
         next_pin[i]    = cfg[i].lock_en ? next_lock[i] : gp_out[i];
         next_pin_oe[i] = cfg[i].lock_en ? 1'b1 : gp_oe[i];
         ev[i]          = next_lock[i] && !lock[i];
         ev[i+2]        = lock[i] && !next_lock[i];
         ev[i+4]        = (st[i] == ST_ACQ) && (next_acq[i] == 16'h0000) &&
                          !cfg_wr[i] && (next_st[i] == ST_ACQ);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: a new event outranks a clear in the same cycle
   always_comb begin
      next_irq_st = irq_st;
      if (wr && PADDR_IN == ADDR_IRQ_CLR) begin
         next_irq_st = irq_st & ~PWDATA_IN[5:0];
      end
      next_irq_st = next_irq_st | ev;
      next_irq    = |(next_irq_st & next_irq_en);
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < NCIRC; i++) begin
            cfg[i]  <= pcm_cfg_t'({CFG_RST[23:0], 16'h0000});
            st[i]   <= ST_IDLE;
            cnt[i]  <= 16'h0000;
            per[i]  <= 16'h0000;
            acq[i]  <= 16'h0000;
            acc[i]  <= 32'h0000_0000;
            hold[i] <= 16'h0000;
         end
         gen     <= '0;
         lock    <= '0;
         gp_out  <= '0;
         gp_oe   <= '0;
         pin     <= '0;
         pin_oe  <= '0;
         irq_st  <= 6'h00;
         irq_en  <= 6'h00;
         irq     <= 1'b0;
         rdata   <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         for (int i = 0; i < NCIRC; i++) begin
            cfg[i]  <= next_cfg[i];
            st[i]   <= next_st[i];
            cnt[i]  <= next_cnt[i];
            per[i]  <= next_per[i];
            acq[i]  <= next_acq[i];
            acc[i]  <= next_acc[i];
            hold[i] <= next_hold[i];
         end
         gen     <= next_gen;
         lock    <= next_lock;
         gp_out  <= next_gp_out;
         gp_oe   <= next_gp_oe;
         pin     <= next_pin;
         pin_oe  <= next_pin_oe;
         irq_st  <= next_irq_st;
         irq_en  <= next_irq_en;
         irq     <= next_irq;
         rdata   <= next_rdata;
         pready  <= next_pready;
         pslverr <= next_pslverr && next_pready;
      end
   end

   assign PRDATA_OUT      = rdata;
   assign PREADY_OUT      = pready;
   assign PSLVERR_OUT     = pslverr;
   assign GEN_CLK_OUT     = gen;
   assign LOCK_PIN_OUT    = pin;
   assign LOCK_PIN_OE_OUT = pin_oe;
   assign IRQ_OUT         = irq;

   ////////////////////////////////////////////////////////////////////////
   // checks; helper counts run length of each level of generated clock 0
   // n_tog skips the first half period, cut short by the phase start point
   logic [31:0] run_len, prev_len;
   logic [1:0]  n_tog;
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN || st[0] != ST_RUN) begin
         run_len  <= 32'h0000_0000;
         prev_len <= 32'h0000_0000;
         n_tog    <= 2'b00;
      end else if (next_gen[0] != gen[0]) begin
         run_len  <= 32'h0000_0000;
         prev_len <= run_len;
         n_tog    <= (n_tog == 2'b10) ? n_tog : n_tog + 2'b01;
      end else begin
         run_len  <= run_len + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence s_setup;
      PSEL_IN && !PENABLE_IN;
   endsequence
   sequence s_access;
      PSEL_IN && PENABLE_IN;
   endsequence

   chk_apb_answer: assert property (
      s_setup ##1 s_access |-> ##1 PREADY_OUT ##1 !PREADY_OUT)
      else $error("apb answer not on second access cycle");
   chk_lock_acq: assert property (
      (st[0] == ST_ACQ || st[0] == ST_IDLE) |-> !lock[0])
      else $error("lock high while not locked");
   chk_lock_after: assert property (
      (st[0] == ST_ACQ && next_st[0] == ST_HOLD) |=> lock[0])
      else $error("lock not raised on acquisition");
   chk_restart_cfg: assert property (
      cfg_wr[0] |=> (st[0] == ST_ACQ) && !lock[0] && !GEN_CLK_OUT[0])
      else $error("config write did not restart acquisition");
   chk_acq_bound: assert property (
      acq[0] <= 16'(LOCK_CYC - 1))
      else $error("acquisition counter beyond lock time");
   chk_pin_lock: assert property (
      cfg[0].lock_en && $past(cfg[0].lock_en) |->
         LOCK_PIN_OE_OUT[0] && (LOCK_PIN_OUT[0] == lock[0]))
      else $error("lock pin not showing lock");
   chk_pin_gpio: assert property (
      !cfg[0].lock_en && $stable(cfg[0].lock_en) |->
         LOCK_PIN_OE_OUT[0] == $past(gp_oe[0]))
      else $error("gpio enable not passed to pin");
   chk_run_valid: assert property (
      (st[0] == ST_ACQ && next_st[0] == ST_HOLD) |-> valid[0])
      else $error("locked on invalid setting");
   chk_duty_balance: assert property (
      (st[0] == ST_RUN && $past(st[0]) == ST_RUN && prev_len != 0 &&
       next_st[0] == ST_RUN && n_tog == 2'b10 &&
       next_gen[0] != gen[0]) |->
         (run_len <= prev_len + 1) && (prev_len <= run_len + 1))
      else $error("generated clock half periods unbalanced");
   chk_irq_level: assert property (
      ##1 IRQ_OUT == |($past(next_irq_st) & $past(next_irq_en)))
      else $error("irq output not matching enabled status");
   chk_idle_low: assert property (
      st[0] == ST_IDLE |=> !GEN_CLK_OUT[0] || st[0] != ST_IDLE)
      else $error("clock running without reference");
endmodule : pcm_clock_mult
`default_nettype wire

// >>> src/pcm_pkg.sv
// constants, config layout and helpers for the dual clock multiplier
// assumes a 50 MHz system clock and a 32-bit APB register port
package pcm_pkg;
   localparam int          NCIRC        = 2;
   localparam int          CLK_MHZ      = 50;
   // register byte offsets
   localparam logic [7:0]  ADDR_CFG0    = 8'h00;
   localparam logic [7:0]  ADDR_DLY0    = 8'h04;
   localparam logic [7:0]  ADDR_CFG1    = 8'h08;
   localparam logic [7:0]  ADDR_DLY1    = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS  = 8'h10;
   localparam logic [7:0]  ADDR_IRQ_ST  = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_CLR = 8'h18;
   localparam logic [7:0]  ADDR_IRQ_EN  = 8'h1C;
   localparam logic [7:0]  ADDR_GPIO    = 8'h20;
   // config word field positions
   localparam int          M_LSB        = 0;
   localparam int          K_LSB        = 8;
   localparam int          N_LSB        = 16;
   localparam int          PH_LSB       = 21;
   localparam int          LEN_BIT      = 23;
   // ratio limits
   localparam int          MK_MIN       = 2;
   localparam int          MK_MAX       = 160;
   localparam int          N_MIN        = 1;
   localparam int          N_MAX        = 16;
   // frequency limits, output in tenths of MHz, oscillator in MHz
   localparam int          F0_MIN_X10   = 15;
   localparam int          F1_MIN_X10   = 200;
   localparam int          FOUT_MAX_X10 = 3350;
   localparam int          VCO_MIN_MHZ  = 200;
   localparam int          VCO_MAX_MHZ  = 500;
   // acquisition time
   localparam int          LOCK_US      = 40;
   localparam int          LOCK_CYC     = LOCK_US * CLK_MHZ;
   localparam logic [15:0] PER_MAX      = 16'hFFFF;
   // reset values
   localparam logic [31:0] CFG_RST      = 32'h0001_0202;

   typedef struct packed {
      logic [1:0]  phase;
      logic        lock_en;
      logic [4:0]  n;
      logic [7:0]  k;
      logic [7:0]  m;
      logic [15:0] delay;
   } pcm_cfg_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ACQ  = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_RUN  = 4'b1000
   } pcm_state_t;

   // accumulator threshold: ref period times n times k
   function automatic logic [28:0] pcm_thresh(input pcm_cfg_t c,
                                              input logic [15:0] per);
      pcm_thresh = 29'(per * c.n * c.k);
   endfunction : pcm_thresh

   // ratio, output range, oscillator range and delay limit
   function automatic logic pcm_valid(input pcm_cfg_t c,
                                      input logic [15:0] per,
                                      input logic second);
      logic [47:0] t;
      logic [47:0] fo;
      logic [47:0] pn;
      logic [47:0] fmin;
      t    = 48'(pcm_thresh(c, per));
      fo   = 48'(c.m) * 48'd500;
      pn   = 48'(per) * 48'(c.n);
      fmin = second ? 48'(F1_MIN_X10) : 48'(F0_MIN_X10);
      pcm_valid = (c.m >= MK_MIN) && (c.m <= MK_MAX) &&
                  (c.k >= MK_MIN) && (c.k <= MK_MAX) &&
                  (c.n >= N_MIN) && (c.n <= N_MAX) && (per != 16'h0000) &&
                  (fo >= fmin * t) && (fo <= 48'(FOUT_MAX_X10) * t) &&
                  (48'(c.m) * 48'(CLK_MHZ) >= 48'(VCO_MIN_MHZ) * pn) &&
                  (48'(c.m) * 48'(CLK_MHZ) <= 48'(VCO_MAX_MHZ) * pn) &&
                  (48'(c.delay) * 48'(c.m) <= t);
   endfunction : pcm_valid
endpackage : pcm_pkg

// >>> bench/pcm_ref_src.sv
// reference clock source model for one multiplier circuit
// assumes only run_in from the bench; its phase is free of the system clock
`timescale 1ns/1ps
`default_nettype none
module pcm_ref_src #(
   parameter int HALF_NS = 40,
   parameter int SKEW_NS = 7
) (
   input  wire logic run_in,
   output logic      ref_out
);
   ////////////////////////////////////////////////////////////////////////
   // toggles only while running, stands low otherwise, like a gated source
   initial begin
      ref_out = 1'b0;
      #(SKEW_NS);
      forever begin
         if (run_in === 1'b1) begin
            #(HALF_NS);
            ref_out = ~ref_out;
         end else begin
            ref_out = 1'b0;
            @(posedge run_in);
         end
      end
   end
endmodule : pcm_ref_src
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the dual clock multiplier with apb registers
// assumes two free-running reference sources of 80 ns period (4 cycles)
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pcm_pkg::*;
   typedef struct packed {
      logic [31:0] cfg;
      logic [15:0] dly;
      logic [1:0]  ok;
   } pcm_row_t;
   logic             clk, rst_n, psel, pen, pwr, pready, pslverr, irq, run;
   logic             err;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [NCIRC-1:0] ref_clk, gen, pin_in, pin_out, pin_oe, pin_ext;
   int               error_cnt, n_compared, cnt_hi, cnt_rise;
   pcm_row_t         rows [12];

   ////////////////////////////////////////////////////////////////////////
   // device, its two reference sources, and the shared pin wire levels
   pcm_clock_mult dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .REF_CLK_IN(ref_clk), .GEN_CLK_OUT(gen),
      .LOCK_PIN_IN(pin_in), .LOCK_PIN_OUT(pin_out),
      .LOCK_PIN_OE_OUT(pin_oe), .IRQ_OUT(irq));
   pcm_ref_src #(.HALF_NS(40), .SKEW_NS(7)) ref0_u (.run_in(run),
      .ref_out(ref_clk[0]));
   pcm_ref_src #(.HALF_NS(40), .SKEW_NS(13)) ref1_u (.run_in(run),
      .ref_out(ref_clk[1]));
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);

   // 50 mhz system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("counts: %0d compared, %0d mismatched", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic fail(input string msg);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask : fail

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask : chk

   task automatic chk_rng(input int got, input int lo, input int hi,
                          input string what);
      n_compared++;
      if (got < lo || got > hi) fail($sformatf("%s count %0d", what, got));
   endtask : chk_rng

   // apb master: request held until pready is sampled high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd   = prdata;
      err  = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (i == 16) begin
         fail("no pready");
         end_of_test();
      end
   endtask : apb

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles

   // counts high cycles and rising edges of the first generated clock
   task automatic count_gen(input int n);
      logic prev;
      prev     = gen[0];
      cnt_hi   = 0;
      cnt_rise = 0;
      repeat (n) begin
         @(posedge clk);
         if (gen[0] === 1'b1) cnt_hi++;
         if (gen[0] === 1'b1 && prev === 1'b0) cnt_rise++;
         prev = gen[0];
      end
   endtask : count_gen

   // config word with lock pin enabled
   function automatic logic [31:0] mk(input int m, input int k, input int n,
                                      input int ph);
      return {8'h00, 1'b1, 2'(ph), 5'(n), 8'(k), 8'(m)};
   endfunction : mk

   task automatic set_both(input logic [31:0] c, input logic [15:0] d);
      apb(1'b1, ADDR_CFG0, c);
      apb(1'b1, ADDR_DLY0, 32'(d));
      apb(1'b1, ADDR_CFG1, c);
      apb(1'b1, ADDR_DLY1, 32'(d));
   endtask : set_both

   ////////////////////////////////////////////////////////////////////////
   // main sequence: reset, row table, then hand-written cases
   initial begin
      {rst_n, psel, pen, pwr, run} = 5'b0_0000;
      paddr      = 8'h00;
      pwdata     = 32'h0000_0000;
      pin_ext    = 2'b10;
      error_cnt  = 0;
      n_compared = 0;
      rows[0]  = '{mk(16, 20, 1, 0), 16'h0005, 2'b01};  // at limit
      rows[1]  = '{mk(16, 20, 1, 0), 16'h0006, 2'b00};  // over
      rows[2]  = '{mk(16, 2, 1, 1), 16'h0000, 2'b11};
      rows[3]  = '{mk(15, 2, 1, 0), 16'h0000, 2'b00};   // low
      rows[4]  = '{mk(40, 2, 1, 2), 16'h0000, 2'b11};   // 500
      rows[5]  = '{mk(41, 2, 1, 0), 16'h0000, 2'b00};   // high
      rows[6]  = '{mk(16, 134, 1, 0), 16'h0000, 2'b00};
      rows[7]  = '{mk(16, 133, 1, 3), 16'h0000, 2'b01};
      rows[8]  = '{mk(16, 10, 1, 0), 16'h0000, 2'b11};
      rows[9]  = '{mk(16, 11, 1, 0), 16'h0000, 2'b01};
      rows[10] = '{mk(16, 1, 1, 0), 16'h0000, 2'b00};   // k min
      rows[11] = '{mk(16, 2, 0, 0), 16'h0000, 2'b00};   // n min
      repeat (2) @(posedge clk);
      chk(32'({gen, pin_out, pin_oe, irq}), 32'h0000_0000, "in reset");
      rst_n <= 1'b1;
      run   <= 1'b1;
      apb(1'b0, ADDR_CFG0, 32'h0000_0000);
      chk(rd, CFG_RST, "cfg0 reset");
      apb(1'b0, 8'h24, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001, "unmapped");
      apb(1'b0, ADDR_IRQ_CLR, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "clear reads 0");
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_000C, 32'h0000_0000, "no lock");
      $display("test reset done");
      // one row per config: both circuits locked or refused in time
      foreach (rows[i]) begin
         set_both(rows[i].cfg, rows[i].dly);
         cycles(LOCK_CYC + 20);
         chk(32'(pin_out), 32'(rows[i].ok), "lock pins");
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
         chk(rd & 32'h0000_003F, 32'({rows[i].ok, rows[i].ok, 2'b11}),
             "status");
      end
      $display("test table done");
      // circuit 0 locked on pin, circuit 1 pin left to gpio
      apb(1'b1, ADDR_IRQ_CLR, 32'h0000_003F);
      apb(1'b1, ADDR_IRQ_EN, 32'h0000_0001);
      apb(1'b1, ADDR_GPIO, 32'h0000_000D);
      set_both(mk(16, 80, 1, 0), 16'h0014);
      apb(1'b1, ADDR_CFG1, mk(16, 80, 1, 0) ^ 32'h0080_0000);
      cycles(LOCK_CYC + 20);
      chk(32'({pin_oe, pin_out}), 32'h0000_000D, "pins");
      apb(1'b0, ADDR_GPIO, 32'h0000_0000);
      chk(rd & 32'h0000_003F, 32'h0000_001D, "gpio in");
      apb(1'b1, ADDR_GPIO, 32'h0000_0001);
      cycles(4);
      apb(1'b0, ADDR_GPIO, 32'h0000_0000);
      chk(rd & 32'h0000_003F, 32'h0000_0031, "gpio ext");
      // 320 cycle threshold over m 16: 20 cycle output period
      count_gen(1000);
      chk_rng(cnt_rise, 49, 51, "rises");
      chk_rng(cnt_hi, 450, 550, "high time");
      $display("test pins done");
      // lock gained raises irq, cleared by w1c
      chk(32'(irq), 32'h0000_0001, "irq set");
      apb(1'b1, ADDR_IRQ_CLR, 32'h0000_0001);
      cycles(2);
      chk(32'(irq), 32'h0000_0000, "irq cleared");
      // invalid oscillator range times out, then masked
      apb(1'b1, ADDR_IRQ_EN, 32'h0000_0010);
      apb(1'b1, ADDR_CFG0, mk(15, 80, 1, 0));
      cycles(LOCK_CYC + 100);
      chk(32'(irq), 32'h0000_0001, "timeout irq");
      apb(1'b1, ADDR_IRQ_EN, 32'h0000_0000);
      cycles(2);
      apb(1'b0, ADDR_IRQ_ST, 32'h0000_0000);
      chk(rd & 32'h0000_0010, 32'h0000_0010, "sticky");
      chk(32'(irq), 32'h0000_0000, "masked");
      $display("test irq done");
      // reset in mid-run while locked drops the lock at once
      apb(1'b1, ADDR_CFG0, mk(16, 80, 1, 0));
      cycles(LOCK_CYC + 20);
      chk(32'(pin_out[0]), 32'h0000_0001, "relock");
      rst_n <= 1'b0;
      cycles(2);
      chk(32'({gen, pin_out, pin_oe, irq}), 32'h0000_0000, "reset");
      rst_n <= 1'b1;
      apb(1'b0, ADDR_CFG0, 32'h0000_0000);
      chk(rd, CFG_RST, "cfg0 again");
      $display("test second reset done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
